// ---- rtl/lsu_map.svh ----
`ifndef LSU_MAP_SVH
`define LSU_MAP_SVH

// Special function register addresses.
`define LSU_OFS_PRESCALER 8'hE1
`define LSU_OFS_EP1_TX_DATA 8'hE6
`define LSU_OFS_EP0_TX_DATA 8'hE7
`define LSU_OFS_IRQ_STATUS 8'hE8
`define LSU_OFS_IRQ_ENABLE 8'hE9
`define LSU_OFS_EP0_TX_CONTROL 8'hEA
`define LSU_OFS_EP1_TX_CONTROL 8'hEB
`define LSU_OFS_USB_CONTROL 8'hEC
`define LSU_OFS_EP0_STATUS 8'hED
`define LSU_OFS_DEVICE_ADDRESS 8'hEE
`define LSU_OFS_EP0_RX_DATA 8'hEF

// Every register clears to this value.
`define LSU_RESET_BYTE 8'h00

// Token packet identifiers.
`define LSU_PID_SETUP 4'hD
`define LSU_PID_IN 4'h9
`define LSU_PID_OUT 4'h1

// Endpoint-0 status register fields.
`define LSU_STA_EXPECTED_PID 7
`define LSU_STA_SETUP 6
`define LSU_STA_IN 5
`define LSU_STA_OUT 4

// Endpoint-0 transmit control fields.
`define LSU_C0_TX_PID 7
`define LSU_C0_STALL 6
`define LSU_C0_TX_EN 5
`define LSU_C0_RX_EN 4

// Endpoint-1/2 transmit control fields.
`define LSU_C1_TX_PID 7
`define LSU_C1_SELECT 6
`define LSU_C1_TX_EN 5

// Usb control fields.
`define LSU_C2_EP2_EN 3
`define LSU_C2_EP1_EN 2
`define LSU_C2_STALL2 1
`define LSU_C2_STALL1 0

// Interrupt flags set by the transactions.
`define LSU_IS_TX0_DONE 4
`define LSU_IS_RX0_DONE 3
`define LSU_IS_TX1_DONE 2

// Receive buffer shape and the byte count ceiling.
`define LSU_RX_FIFO_WIDTH 8
`define LSU_RX_FIFO_DEPTH 16
`define LSU_COUNT_MAX 4'hF

`endif

// ---- rtl/lsu_pkg.sv ----
package lsu_pkg;

	// Answer that the device gives to a token.
	typedef enum logic [1:0] {
		LSU_RESP_ACK,
		LSU_RESP_NAK,
		LSU_RESP_STALL,
		LSU_RESP_DATA
	} lsu_resp_t;

	// Transaction in progress on the link.
	typedef enum logic [1:0] {
		LSU_TXN_IDLE,
		LSU_TXN_SETUP,
		LSU_TXN_OUT,
		LSU_TXN_IN
	} lsu_txn_t;

endpackage

// ---- rtl/lsu_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.svh"

module lsu_prescaler (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Divisor and the resulting usb logic tick.
	input wire logic [7:0] divisor,
	output logic tick
);

	// Complete state: half-rate toggle, divide counter and the tick flop.
	typedef struct packed {
		logic half;
		logic [7:0] cnt;
		logic tick;
	} lsu_pre_state_t;

	lsu_pre_state_t s;
	lsu_pre_state_t next_s;

	// Divides by two, then by divisor plus one, giving one tick per period.
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.half = ~s.half;
		if (s.half) begin
			if (s.cnt >= divisor) begin
				next_s.cnt = 8'h00;
				next_s.tick = 1'b1; // R9
			end else begin
				next_s.cnt = s.cnt + 8'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	// The fixed divide by two never lets two ticks touch.
	AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (!rst_n) // R9
		tick |=> !tick)
		else $error("Usb tick came on two adjacent cycles.");

endmodule
`default_nettype wire

// ---- rtl/lsu_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module lsu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Filling side.
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side.
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);

	localparam int AW = $clog2(DEPTH);

	// Complete state: storage, pointers and fill level.
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] level;
	} lsu_fifo_state_t;

	lsu_fifo_state_t s;
	lsu_fifo_state_t next_s;
	logic push;
	logic pop;

	// Full and empty follow the fill level exactly.
	assign in_ready = (s.level != DEPTH[AW:0]);
	assign out_valid = (s.level != '0);
	assign out_data = s.mem[s.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Stores on push, advances on pop, and tracks the level.
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr = s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = s.rd + 1'b1;
		end
		if (push && !pop) begin
			next_s.level = s.level + 1'b1;
		end else if (pop && !push) begin
			next_s.level = s.level - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// ---- rtl/lsu_endpoint_regs.sv ----
// Function
// R1 - Compare expected data PID with received type
// R2 - Setup flag bit 6 on PID 1101
// R3 - IN flag bit 5 on IN token
// R4 - OUT flag bit 4 on OUT token
// R5 - Received byte count in bits 3..0
// R6 - Received endpoint-0 bytes read at EFh
// R7 - Endpoint-0 transmit byte written at E7h
// R8 - Shared endpoint-1/2 transmit byte at E6h
// R9 - Usb clock is mclk/2/(prescaler+1)
// R10 - Software uses 12/24/36 MHz, prescaler 0/1/2
// R11 - Line driver released unless transmitting
// R12 - Each data line has single-ended receiver
// R13 - Endpoint-0 IN NAKed when disabled or done
// R14 - Stall bit answers STALL, setup clears it
// R15 - Endpoint-1/2 data PID from software bit
// R16 - Endpoint-2 IN NAKed when selector shows endpoint 1
// R17 - Status fields update together per transaction
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.svh"

module lsu_endpoint_regs (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Special function register port.
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// Decoded tokens from the serial engine.
	input wire logic tok_valid,
	input wire logic [3:0] tok_pid,
	input wire logic [3:0] tok_ep,
	// Received data bytes and end of data packet.
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic rx_ready,
	input wire logic rx_end,
	input wire logic rx_data1,
	// End of the whole transaction.
	input wire logic txn_done,
	// Answer to each token.
	output logic resp_valid,
	output lsu_pkg::lsu_resp_t resp_code,
	output logic resp_data1,
	output logic [3:0] resp_count,
	output logic [7:0] tx_ep0_byte,
	output logic [7:0] tx_ep12_byte,
	output logic seq_error,
	// Usb logic clock tick.
	output logic usb_clk_tick,
	// Data line pins and their receivers.
	input wire logic drive_en,
	input wire logic drive_dp,
	input wire logic drive_dm,
	input wire logic line_dp_in,
	input wire logic line_dm_in,
	output logic line_dp_out,
	output logic line_dm_out,
	output logic line_oe_n,
	output logic line_diff,
	output logic line_se_dp,
	output logic line_se_dm,
	output logic line_se0
);

	// Complete state of the block.
	typedef struct packed {
		logic [7:0] prescaler;
		logic [7:0] ep1_tx;
		logic [7:0] ep0_tx;
		logic [7:0] irq_sta;
		logic [7:0] irq_en;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] status;
		logic [7:0] dev_addr;
		logic [7:0] rdata;
		lsu_pkg::lsu_txn_t txn;
		logic [3:0] pend_ep;
		logic [3:0] pend_cnt;
		logic pend_sent;
		logic pend_ack;
		logic resp_valid;
		lsu_pkg::lsu_resp_t resp_code;
		logic resp_data1;
		logic [3:0] resp_count;
		logic seq_error;
		logic line_diff;
		logic line_se_dp;
		logic line_se_dm;
		logic line_se0;
		logic oe_n;
		logic dp_out;
		logic dm_out;
	} lsu_regs_state_t;

	lsu_regs_state_t s;
	lsu_regs_state_t next_s;

	// Receive buffer wires.
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_pop;
	logic rx_accept;

	// Divider for the usb logic clock.
	lsu_prescaler u_pre (
		.mclk(mclk),
		.rst_n(rst_n),
		.divisor(s.prescaler), // R9
		.tick(usb_clk_tick)
	);

	// Endpoint-0 receive bytes wait here until software reads them.
	lsu_fifo #(
		.WIDTH(`LSU_RX_FIFO_WIDTH),
		.DEPTH(`LSU_RX_FIFO_DEPTH)
	) u_rx_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_data(rx_byte),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);

	// Only endpoint-0 SETUP or OUT data is kept; other bytes are drained away.
	assign rx_accept = (s.pend_ep == 4'h0) &&
		(s.txn == lsu_pkg::LSU_TXN_SETUP || s.txn == lsu_pkg::LSU_TXN_OUT);
	assign fifo_in_valid = rx_valid && rx_accept;
	assign rx_ready = rx_accept ? fifo_in_ready : 1'b1;
	assign fifo_pop = sfr_rd && (sfr_addr == `LSU_OFS_EP0_RX_DATA) && fifo_out_valid; // R6

	// Register writes, token answers, data counting and status commit.
	always_comb begin
		next_s = s;
		next_s.resp_valid = 1'b0;
		// Software writes land first so that hardware events below win.
		if (sfr_wr) begin
			case (sfr_addr)
				`LSU_OFS_PRESCALER: begin
					next_s.prescaler = sfr_wdata; // R9
				end
				`LSU_OFS_EP1_TX_DATA: begin
					next_s.ep1_tx = sfr_wdata; // R8
				end
				`LSU_OFS_EP0_TX_DATA: begin
					next_s.ep0_tx = sfr_wdata; // R7
				end
				`LSU_OFS_IRQ_STATUS: begin
					next_s.irq_sta = sfr_wdata;
				end
				`LSU_OFS_IRQ_ENABLE: begin
					next_s.irq_en = sfr_wdata;
				end
				`LSU_OFS_EP0_TX_CONTROL: begin
					next_s.ctrl0 = sfr_wdata;
				end
				`LSU_OFS_EP1_TX_CONTROL: begin
					next_s.ctrl1 = sfr_wdata; // R15
				end
				`LSU_OFS_USB_CONTROL: begin
					next_s.ctrl2 = {3'b000, sfr_wdata[4:0]};
				end
				`LSU_OFS_EP0_STATUS: begin
					// Only the expected PID bit is writable here.
					next_s.status[`LSU_STA_EXPECTED_PID] = sfr_wdata[`LSU_STA_EXPECTED_PID]; // R1
				end
				`LSU_OFS_DEVICE_ADDRESS: begin
					next_s.dev_addr = sfr_wdata;
				end
				default: begin
				end
			endcase
		end
		// Reads are captured into the data flop; unmapped addresses read zero.
		if (sfr_rd) begin
			case (sfr_addr)
				`LSU_OFS_PRESCALER: next_s.rdata = s.prescaler;
				`LSU_OFS_EP1_TX_DATA: next_s.rdata = s.ep1_tx;
				`LSU_OFS_EP0_TX_DATA: next_s.rdata = s.ep0_tx;
				`LSU_OFS_IRQ_STATUS: next_s.rdata = s.irq_sta;
				`LSU_OFS_IRQ_ENABLE: next_s.rdata = s.irq_en;
				`LSU_OFS_EP0_TX_CONTROL: next_s.rdata = s.ctrl0;
				`LSU_OFS_EP1_TX_CONTROL: next_s.rdata = s.ctrl1;
				`LSU_OFS_USB_CONTROL: next_s.rdata = s.ctrl2;
				`LSU_OFS_EP0_STATUS: next_s.rdata = s.status;
				`LSU_OFS_DEVICE_ADDRESS: next_s.rdata = s.dev_addr;
				`LSU_OFS_EP0_RX_DATA: next_s.rdata = fifo_out_valid ? fifo_out_data : 8'h00; // R6
				default: next_s.rdata = 8'h00;
			endcase
		end
		// A SETUP, OUT or IN token opens a transaction and is answered on the next cycle.
		if (tok_valid) begin
			next_s.pend_ep = tok_ep;
			next_s.pend_cnt = 4'h0;
			next_s.resp_valid = 1'b1;
			next_s.resp_data1 = 1'b0;
			next_s.resp_count = 4'h0;
			next_s.resp_code = lsu_pkg::LSU_RESP_STALL;
			case (tok_pid)
				`LSU_PID_SETUP: begin
					next_s.txn = lsu_pkg::LSU_TXN_SETUP;
					next_s.resp_code = lsu_pkg::LSU_RESP_ACK;
					if (tok_ep == 4'h0) begin
						next_s.ctrl0[`LSU_C0_STALL] = 1'b0; // R14
					end
				end
				`LSU_PID_OUT: begin
					next_s.txn = lsu_pkg::LSU_TXN_OUT;
					if (tok_ep == 4'h0) begin
						if (s.ctrl0[`LSU_C0_STALL]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_STALL; // R14
						end else if (!s.ctrl0[`LSU_C0_RX_EN] || s.irq_sta[`LSU_IS_RX0_DONE]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_NAK;
						end else begin
							next_s.resp_code = lsu_pkg::LSU_RESP_ACK;
						end
					end
				end
				`LSU_PID_IN: begin
					next_s.txn = lsu_pkg::LSU_TXN_IN;
					if (tok_ep == 4'h0) begin
						if (s.ctrl0[`LSU_C0_STALL]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_STALL; // R14
						end else if (!s.ctrl0[`LSU_C0_TX_EN] || s.irq_sta[`LSU_IS_TX0_DONE]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_NAK; // R13
						end else begin
							next_s.resp_code = lsu_pkg::LSU_RESP_DATA;
							next_s.resp_data1 = s.ctrl0[`LSU_C0_TX_PID];
							next_s.resp_count = s.ctrl0[3:0];
						end
					end else if (tok_ep == 4'h1) begin
						if (s.ctrl2[`LSU_C2_STALL1]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_STALL;
						end else if (!s.ctrl2[`LSU_C2_EP1_EN] || !s.ctrl1[`LSU_C1_TX_EN] ||
							s.irq_sta[`LSU_IS_TX1_DONE]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_NAK;
						end else begin
							next_s.resp_code = lsu_pkg::LSU_RESP_DATA;
							next_s.resp_data1 = s.ctrl1[`LSU_C1_TX_PID]; // R15
							next_s.resp_count = s.ctrl1[3:0];
						end
					end else if (tok_ep == 4'h2) begin
						if (s.ctrl2[`LSU_C2_STALL2]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_STALL;
						end else if (!s.ctrl2[`LSU_C2_EP2_EN] || !s.ctrl1[`LSU_C1_TX_EN] ||
							s.irq_sta[`LSU_IS_TX1_DONE] || !s.ctrl1[`LSU_C1_SELECT]) begin
							next_s.resp_code = lsu_pkg::LSU_RESP_NAK; // R16
						end else begin
							next_s.resp_code = lsu_pkg::LSU_RESP_DATA;
							next_s.resp_data1 = s.ctrl1[`LSU_C1_TX_PID]; // R15
							next_s.resp_count = s.ctrl1[3:0];
						end
					end
				end
				default: begin
					next_s.resp_valid = 1'b0;
				end
			endcase
			next_s.pend_sent = (next_s.resp_code == lsu_pkg::LSU_RESP_DATA);
			next_s.pend_ack = (next_s.resp_code == lsu_pkg::LSU_RESP_ACK);
		end
		// Count bytes taken into the buffer, saturating at the field maximum.
		if (fifo_in_valid && fifo_in_ready && s.pend_cnt != `LSU_COUNT_MAX) begin
			next_s.pend_cnt = s.pend_cnt + 4'h1; // R5
		end
		// The data packet type is checked against the expected PID bit.
		if (rx_end && rx_accept) begin
			next_s.seq_error = (rx_data1 != s.status[`LSU_STA_EXPECTED_PID]); // R1
		end
		// Flags and count for endpoint 0 are committed in one step.
		if (txn_done && s.txn != lsu_pkg::LSU_TXN_IDLE) begin
			if (s.pend_ep == 4'h0) begin
				next_s.status[`LSU_STA_SETUP] = (s.txn == lsu_pkg::LSU_TXN_SETUP); // R2 R17
				next_s.status[`LSU_STA_IN] = (s.txn == lsu_pkg::LSU_TXN_IN); // R3 R17
				next_s.status[`LSU_STA_OUT] = (s.txn == lsu_pkg::LSU_TXN_OUT); // R4 R17
				next_s.status[3:0] = s.pend_cnt; // R5 R17
				if (s.pend_sent) begin
					next_s.irq_sta[`LSU_IS_TX0_DONE] = 1'b1;
				end
				if (s.pend_ack) begin
					next_s.irq_sta[`LSU_IS_RX0_DONE] = 1'b1;
				end
			end else if (s.pend_sent) begin
				next_s.irq_sta[`LSU_IS_TX1_DONE] = 1'b1;
			end
			next_s.txn = lsu_pkg::LSU_TXN_IDLE;
		end
		// Pins: the driver is released whenever nothing is being sent.
		next_s.oe_n = ~drive_en; // R11
		next_s.dp_out = drive_en & drive_dp;
		next_s.dm_out = drive_en & drive_dm;
		// Each line is sampled on its own as well as differentially.
		next_s.line_diff = line_dp_in & ~line_dm_in;
		next_s.line_se_dp = line_dp_in; // R12
		next_s.line_se_dm = line_dm_in; // R12
		next_s.line_se0 = ~line_dp_in & ~line_dm_in; // R12
	end

	// State register; every field clears on reset except oe_n, which is set to release the driver.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops.
	assign sfr_rdata = s.rdata;
	assign resp_valid = s.resp_valid;
	assign resp_code = s.resp_code;
	assign resp_data1 = s.resp_data1;
	assign resp_count = s.resp_count;
	assign tx_ep0_byte = s.ep0_tx;
	assign tx_ep12_byte = s.ep1_tx;
	assign seq_error = s.seq_error;
	assign line_dp_out = s.dp_out;
	assign line_dm_out = s.dm_out;
	assign line_oe_n = s.oe_n;
	assign line_diff = s.line_diff;
	assign line_se_dp = s.line_se_dp;
	assign line_se_dm = s.line_se_dm;
	assign line_se0 = s.line_se0;

	// Endpoint-0 transaction closing.
	sequence s_ep0_close;
		txn_done && s.pend_ep == 4'h0 && s.txn != lsu_pkg::LSU_TXN_IDLE;
	endsequence

	// An endpoint-0 IN token.
	sequence s_ep0_in;
		tok_valid && tok_pid == `LSU_PID_IN && tok_ep == 4'h0;
	endsequence

	AST_SETUP_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // R2
		s_ep0_close and (s.txn == lsu_pkg::LSU_TXN_SETUP) |=> s.status[6] && !s.status[5])
		else $error("Setup flag not set after setup transaction.");

	AST_IN_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // R3
		s_ep0_close and (s.txn == lsu_pkg::LSU_TXN_IN) |=> s.status[5] && !s.status[4])
		else $error("IN flag not set after IN transaction.");

	AST_OUT_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // R4
		s_ep0_close and (s.txn == lsu_pkg::LSU_TXN_OUT) |=> s.status[4] && !s.status[6])
		else $error("OUT flag not set after OUT transaction.");

	AST_COUNT_COMMIT: assert property (@(posedge mclk) disable iff (!rst_n) // R5
		s_ep0_close |=> s.status[3:0] == $past(s.pend_cnt))
		else $error("Received byte count not committed.");

	AST_STATUS_STEADY: assert property (@(posedge mclk) disable iff (!rst_n) // R17
		!txn_done && !sfr_wr |=> s.status[6:0] == $past(s.status[6:0]))
		else $error("Status changed outside a transaction end.");

	AST_EP0_NAK: assert property (@(posedge mclk) disable iff (!rst_n) // R13
		s_ep0_in and (!s.ctrl0[6] && (!s.ctrl0[5] || s.irq_sta[4]))
		|=> resp_valid && resp_code == lsu_pkg::LSU_RESP_NAK)
		else $error("Endpoint-0 IN not refused with NAK.");

	AST_EP0_STALL: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		s_ep0_in and s.ctrl0[6] |=> resp_valid && resp_code == lsu_pkg::LSU_RESP_STALL)
		else $error("Endpoint-0 IN not stalled.");

	AST_SETUP_UNSTALL: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		tok_valid && tok_pid == `LSU_PID_SETUP && tok_ep == 4'h0 |=> !s.ctrl0[6])
		else $error("Setup token left the stall bit set.");

	AST_EP2_NAK: assert property (@(posedge mclk) disable iff (!rst_n) // R16
		tok_valid && tok_pid == `LSU_PID_IN && tok_ep == 4'h2 && !s.ctrl2[1] && !s.ctrl1[6]
		|=> resp_code == lsu_pkg::LSU_RESP_NAK)
		else $error("Endpoint-2 IN answered while selector shows endpoint 1.");

	AST_EP12_PID: assert property (@(posedge mclk) disable iff (!rst_n) // R15
		resp_valid && resp_code == lsu_pkg::LSU_RESP_DATA && $past(tok_ep) != 4'h0
		|-> resp_data1 == $past(s.ctrl1[7]))
		else $error("Endpoint-1/2 data PID differs from the software bit.");

	AST_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		!drive_en |=> line_oe_n && !line_dp_out && !line_dm_out)
		else $error("Line driven while not transmitting.");

	AST_SEQ_CHECK: assert property (@(posedge mclk) disable iff (!rst_n) // R1
		rx_end && rx_accept |=> seq_error == ($past(rx_data1) != $past(s.status[7])))
		else $error("Data PID comparison wrong.");

endmodule
`default_nettype wire

// ---- verif/lsu_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host side of the link past the serial engine.
module lsu_host_model (
	// Clock.
	input wire logic mclk,
	// Token toward the device.
	output logic tok_valid,
	output logic [3:0] tok_pid,
	output logic [3:0] tok_ep,
	// Data bytes toward the device.
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic rx_ready,
	output logic rx_end,
	output logic rx_data1,
	output logic txn_done,
	// Line levels at the receivers.
	output logic line_dp_in,
	output logic line_dm_in
);
	// Idle lines: minus line pulled up.
	initial begin
		tok_valid = 1'b0;
		tok_pid = 4'h0;
		tok_ep = 4'h0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_end = 1'b0;
		rx_data1 = 1'b0;
		txn_done = 1'b0;
		line_dp_in = 1'b0;
		line_dm_in = 1'b1;
	end

	// One token; released fields show the inverse.
	task automatic token(input logic [3:0] pid, input logic [3:0] ep);
		tok_pid = pid;
		tok_ep = ep;
		tok_valid = 1'b1;
		@(negedge mclk);
		tok_valid = 1'b0;
		tok_pid = ~pid;
		tok_ep = ~ep;
		@(negedge mclk);
	endtask

	// One byte after gap plus one idle cycles, held for up to eight edges.
	task automatic send(input logic [7:0] b, input int gap, output logic ok);
		int k;
		repeat (gap + 1) @(negedge mclk);
		rx_byte = b;
		rx_valid = 1'b1;
		ok = 1'b0;
		for (k = 0; k < 8 && ok !== 1'b1; k++) begin
			@(posedge mclk);
			ok = rx_ready;
		end
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask

	// Closes a transaction.
	task automatic done();
		txn_done = 1'b1;
		@(negedge mclk);
		txn_done = 1'b0;
		@(negedge mclk);
	endtask

	// Ends a data packet, then the transaction.
	task automatic finish(input logic d1);
		rx_end = 1'b1;
		rx_data1 = d1;
		@(negedge mclk);
		rx_end = 1'b0;
		rx_data1 = ~d1;
		done();
	endtask

	// Sets the levels of both data lines.
	task automatic line(input logic dp, input logic dm);
		line_dp_in = dp;
		line_dm_in = dm;
	endtask
endmodule

`default_nettype wire

// ---- verif/low_speed_usb_endpoint_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lsu_map.svh"
`define CHK(nm, ex, got) check(nm, 16'(ex), 16'(got))

module low_speed_usb_endpoint_regs_tb_top;
	// Bench stimulus and the design's outputs.
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic rd_d = 1'b0;
	logic drive_en = 1'b0, drive_dp = 1'b0, drive_dm = 1'b0;
	logic [7:0] sfr_rdata, tx_ep0_byte, tx_ep12_byte, rx_byte, d;
	logic resp_valid, resp_data1, seq_error, usb_clk_tick, rx_ready, ok;
	lsu_pkg::lsu_resp_t resp_code;
	logic [3:0] resp_count, tok_pid, tok_ep;
	logic line_dp_out, line_dm_out, line_oe_n, line_diff, line_se_dp, line_se_dm, line_se0;
	logic tok_valid, rx_valid, rx_end, rx_data1, txn_done, line_dp_in, line_dm_in;
	int err_count = 0, comparisons = 0, seed = 54769, i, p, n;
	// Notes: reads {mask, value}, answers {mask, code, data1, count}.
	logic [15:0] rdq[$], rn;
	logic [13:0] rsq[$], sn;
	logic [7:0] buf_q[$];
	logic [7:0] rw_addr [7] = '{8'hE1, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEB, 8'hEE};

	// Clock at 50 MHz.
	initial begin
		forever #10 mclk = ~mclk;
	end

	lsu_endpoint_regs dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_ready(rx_ready), .rx_end(rx_end), .rx_data1(rx_data1),
		.txn_done(txn_done), .resp_valid(resp_valid), .resp_code(resp_code),
		.resp_data1(resp_data1), .resp_count(resp_count), .tx_ep0_byte(tx_ep0_byte),
		.tx_ep12_byte(tx_ep12_byte), .seq_error(seq_error), .usb_clk_tick(usb_clk_tick),
		.drive_en(drive_en), .drive_dp(drive_dp), .drive_dm(drive_dm),
		.line_dp_in(line_dp_in), .line_dm_in(line_dm_in), .line_dp_out(line_dp_out),
		.line_dm_out(line_dm_out), .line_oe_n(line_oe_n), .line_diff(line_diff),
		.line_se_dp(line_se_dp), .line_se_dm(line_se_dm), .line_se0(line_se0));

	lsu_host_model host (.mclk(mclk), .tok_valid(tok_valid), .tok_pid(tok_pid),
		.tok_ep(tok_ep), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
		.rx_end(rx_end), .rx_data1(rx_data1), .txn_done(txn_done),
		.line_dp_in(line_dp_in), .line_dm_in(line_dm_in));

	// Counts a comparison, reports a mismatch.
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (e !== g) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Register write, then an idle edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
		@(negedge mclk);
	endtask

	// Register read; its note is queued.
	task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m = 8'hFF);
		rdq.push_back({m, v & m});
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		@(negedge mclk);
	endtask

	// Token with the answer it should get.
	task automatic tok(input logic [3:0] pid, input logic [3:0] ep, input lsu_pkg::lsu_resp_t c,
		input logic d1 = 1'b0, input logic [3:0] cnt = 4'h0, input logic [6:0] m = 7'h60);
		rsq.push_back({m, {c, d1, cnt} & m});
		host.token(pid, ep);
	endtask

	// Empties the receive buffer, then reads once more.
	task automatic drain();
		while (buf_q.size() > 0) begin
			rd(`LSU_OFS_EP0_RX_DATA, buf_q.pop_front());
		end
		rd(`LSU_OFS_EP0_RX_DATA, 8'h00);
	endtask

	// Cycles from one prescaler tick to the next, bounded.
	task automatic gap(output int g);
		int k;
		for (k = 0; k < 40 && usb_clk_tick !== 1'b1; k++) @(negedge mclk);
		@(negedge mclk);
		for (g = 1; g < 40 && usb_clk_tick !== 1'b1; g++) @(negedge mclk);
		if (g >= 40) begin
			err_count++;
			summarize();
		end
	endtask

	// Random bytes with random stalls; sixteen fit.
	task automatic burst(input int cnt);
		int k;
		for (k = 0; k < cnt; k++) begin
			d = 8'($random(seed));
			host.send(d, int'($unsigned($random(seed)) % 3), ok);
			`CHK("rx_accept", k < 16, ok);
			if (ok === 1'b1) buf_q.push_back(d);
		end
	endtask

	// Monitor: an answer takes the oldest note; none left always mismatches.
	always @(posedge mclk) begin
		if (rd_d) begin
			rn = rdq.size() ? rdq.pop_front() : 16'h00FF;
			`CHK("sfr_rdata", rn[7:0], sfr_rdata & rn[15:8]);
		end
		if (resp_valid === 1'b1) begin
			sn = rsq.size() ? rsq.pop_front() : 14'h007F;
			`CHK("resp", sn[6:0], {resp_code, resp_data1, resp_count} & sn[13:7]);
		end
		rd_d <= sfr_rd;
	end

	// Main sequence.
	initial begin
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		`CHK("line_oe_n", 1'b1, line_oe_n);
		for (i = 'hE0; i < 'hF0; i++) rd(8'(i), `LSU_RESET_BYTE);
		// Read-write registers keep a random value.
		for (i = 0; i < 7; i++) begin
			d = 8'($random(seed));
			wr(rw_addr[i], d);
			rd(rw_addr[i], d);
			if (i == 1) `CHK("tx_ep12_byte", d, tx_ep12_byte);
			if (i == 2) `CHK("tx_ep0_byte", d, tx_ep0_byte);
			wr(rw_addr[i], 8'h00);
		end
		wr(`LSU_OFS_EP0_STATUS, 8'hFF);
		rd(`LSU_OFS_EP0_STATUS, 8'h80);
		wr(`LSU_OFS_EP0_STATUS, 8'h00);
		wr(`LSU_OFS_EP0_RX_DATA, 8'($random(seed)));
		rd(`LSU_OFS_EP0_RX_DATA, 8'h00);
		// Prescaler settings for the three allowed clock rates.
		for (p = 0; p < 3; p++) begin
			wr(`LSU_OFS_PRESCALER, 8'(p));
			gap(n);
			`CHK("tick_period", 2 * (p + 1), n);
		end
		// Setup overfilling the buffer.
		tok(`LSU_PID_SETUP, 4'h0, lsu_pkg::LSU_RESP_ACK);
		burst(17);
		host.finish(1'b0);
		rd(`LSU_OFS_EP0_STATUS, 8'h4F);
		`CHK("seq_error", 1'b0, seq_error);
		drain();
		// Out packets of the wrong and then the right data type.
		wr(`LSU_OFS_EP0_STATUS, 8'h80);
		wr(`LSU_OFS_EP0_TX_CONTROL, 8'h10);
		wr(`LSU_OFS_IRQ_STATUS, 8'h00);
		tok(`LSU_PID_OUT, 4'h0, lsu_pkg::LSU_RESP_ACK);
		burst(3);
		host.finish(1'b0);
		rd(`LSU_OFS_EP0_STATUS, 8'h93);
		`CHK("seq_error", 1'b1, seq_error);
		drain();
		wr(`LSU_OFS_IRQ_STATUS, 8'h00);
		tok(`LSU_PID_OUT, 4'h0, lsu_pkg::LSU_RESP_ACK);
		host.finish(1'b1);
		`CHK("seq_error", 1'b0, seq_error);
		rd(`LSU_OFS_EP0_STATUS, 8'h90);
		// In tokens: disabled, sent, then done flag set.
		wr(`LSU_OFS_EP0_TX_CONTROL, 8'h00);
		tok(`LSU_PID_IN, 4'h0, lsu_pkg::LSU_RESP_NAK);
		host.done();
		wr(`LSU_OFS_EP0_TX_CONTROL, 8'hA5);
		tok(`LSU_PID_IN, 4'h0, lsu_pkg::LSU_RESP_DATA, 1'b1, 4'h5, 7'h7F);
		host.done();
		tok(`LSU_PID_IN, 4'h0, lsu_pkg::LSU_RESP_NAK);
		host.done();
		rd(`LSU_OFS_EP0_STATUS, 8'hA0, 8'hF0);
		rd(`LSU_OFS_IRQ_STATUS, 8'h10, 8'h10);
		// Forced stall, cleared by a setup token; an unknown PID gets no answer.
		wr(`LSU_OFS_IRQ_STATUS, 8'h00);
		wr(`LSU_OFS_EP0_TX_CONTROL, 8'hE0);
		tok(`LSU_PID_IN, 4'h0, lsu_pkg::LSU_RESP_STALL);
		host.done();
		tok(`LSU_PID_OUT, 4'h0, lsu_pkg::LSU_RESP_STALL);
		host.done();
		tok(`LSU_PID_SETUP, 4'h0, lsu_pkg::LSU_RESP_ACK);
		host.done();
		rd(`LSU_OFS_EP0_TX_CONTROL, 8'h00, 8'h40);
		host.token(4'h5, 4'h0);
		host.done();
		// Shared endpoint-1/2 buffer.
		wr(`LSU_OFS_USB_CONTROL, 8'h0C);
		wr(`LSU_OFS_EP1_TX_CONTROL, 8'h20);
		tok(`LSU_PID_IN, 4'h2, lsu_pkg::LSU_RESP_NAK);
		host.done();
		tok(`LSU_PID_IN, 4'h1, lsu_pkg::LSU_RESP_DATA, 1'b0, 4'h0, 7'h7F);
		host.done();
		wr(`LSU_OFS_IRQ_STATUS, 8'h00);
		wr(`LSU_OFS_EP1_TX_CONTROL, 8'hE0);
		tok(`LSU_PID_IN, 4'h2, lsu_pkg::LSU_RESP_DATA, 1'b1, 4'h0, 7'h7F);
		host.done();
		// Line driver and receivers for every line state.
		for (i = 0; i < 4; i++) begin
			drive_en = 1'b1;
			drive_dp = i[0];
			drive_dm = i[1];
			host.line(i[0], i[1]);
			repeat (2) @(negedge mclk);
			`CHK("line_oe_n", 1'b0, line_oe_n);
			`CHK("line_out", i[1:0], {line_dm_out, line_dp_out});
			`CHK("line_se", {i == 0, i[1:0]}, {line_se0, line_se_dm, line_se_dp});
			if (i == 1 || i == 2) `CHK("line_diff", i[0], line_diff);
		end
		drive_en = 1'b0;
		host.line(1'b0, 1'b1);
		repeat (2) @(negedge mclk);
		`CHK("line_oe_n", 1'b1, line_oe_n);
		summarize();
	end
endmodule

`default_nettype wire
